// File: include/cmpev_consts.vh
// Constants for the comparator event select block
`ifndef CMPEV_CONSTS_VH
`define CMPEV_CONSTS_VH

`define CMPEV_ADDR_CONTROL   12'h000
`define CMPEV_ADDR_STATUS    12'h004
`define CMPEV_BIT_EVFLAG     15
`define CMPEV_BIT_OUT        13
`define CMPEV_BIT_OP_AMP_MODE     10
`define CMPEV_BIT_INV        8
`define CMPEV_BIT_EDGE_HI    7
`define CMPEV_BIT_EDGE_LO    6
`define CMPEV_BIT_REFSEL     4
`define CMPEV_BIT_CH_HI      1
`define CMPEV_BIT_CH_LO      0
`define CMPEV_CTRL_WMASK     16'h05d3
`define CMPEV_CTRL_RESET     16'h0000
`define CMPEV_EDGE_NONE      2'b00
`define CMPEV_EDGE_RISE      2'b01
`define CMPEV_EDGE_FALL      2'b10
`define CMPEV_EDGE_ANY       2'b11
`define CMPEV_CH_NEG1        2'b00
`define CMPEV_CH_NEG2        2'b01
`define CMPEV_NEG_NONE       2'b00
`define CMPEV_NEG_PIN1       2'b01
`define CMPEV_NEG_PIN2       2'b10

`endif

// File: design/cmpev_edge.v
// Edge detector for the synchronised comparator output
`timescale 1ns/10ps
module cmpev_edge (
    input  wire       i_core_clk,
    input  wire       i_rst,
    input  wire       i_cmp_raw,
    input  wire       i_inversion,
    input  wire [1:0] i_edge_select,
    output wire       o_level,
    output wire       o_hit
);
`include "cmpev_consts.vh"
    reg sync1_reg;
    reg sync2_reg;
    reg prev_reg;
    reg hit;
    wire rise_raw;
    wire fall_raw;

    // Pin is asynchronous to the core clock; first stage read only by second
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            sync1_reg <= i_cmp_raw;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign rise_raw = sync2_reg & ~prev_reg;
    assign fall_raw = ~sync2_reg & prev_reg;
    assign o_level  = sync2_reg ^ i_inversion;

    always @* begin
        case (i_edge_select)
            `CMPEV_EDGE_ANY:  hit = rise_raw | fall_raw;
            `CMPEV_EDGE_FALL: hit = i_inversion ? rise_raw : fall_raw;
            `CMPEV_EDGE_RISE: hit = i_inversion ? fall_raw : rise_raw;
            default:          hit = 1'b0;
        endcase
    end

    assign o_hit = hit;
endmodule

// File: design/cmpev_top.v
// Comparator event select block with APB control register
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
module cmpev_top (
    input  wire        i_core_clk,
    input  wire        i_rst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    input  wire        i_cmp_raw,
    output reg         o_event,
    output reg         o_reference_select,
    output reg  [1:0]  o_negative_select,
    output reg         o_output_inversion,
    output reg         o_op_amp_mode
);
`include "cmpev_consts.vh"
    reg  [15:0] ctrl_reg;
    reg  [15:0] ctrl_next;
    reg         flag_reg;
    reg         flag_next;
    reg         event_next;
    reg         pready_next;
    reg         pslverr_next;
    reg  [31:0] prdata_next;
    reg         refsel_next;
    reg  [1:0]  neg_next;
    reg         inv_next;
    reg         opm_next;
    wire        level;
    wire        hit;
    wire        setup;
    wire        access;
    wire        wr_ctrl;
    wire        clr_flag;
    wire        fire;
    wire [1:0]  edge_field;
    wire [1:0]  ch_field;

    function addr_mapped;
        input [11:0] addr;
        begin
            addr_mapped = (addr == `CMPEV_ADDR_CONTROL) || (addr == `CMPEV_ADDR_STATUS);
        end
    endfunction

    // Bits without storage read back as zero and ignore writes; a control read then puts the output level in bit 13
    function [15:0] ctrl_mask;
        input [15:0] value;
        begin
            ctrl_mask = value & `CMPEV_CTRL_WMASK;
        end
    endfunction

    // Unavailable inputs stay unselected; the analog side ties them to ground
    function [1:0] neg_decode;
        input [1:0] ch;
        input       op_amp_mode;
        begin
            case (ch)
                `CMPEV_CH_NEG1: neg_decode = `CMPEV_NEG_PIN1;
                `CMPEV_CH_NEG2: neg_decode = op_amp_mode ? `CMPEV_NEG_NONE
                                                    : `CMPEV_NEG_PIN2;
                default:        neg_decode = `CMPEV_NEG_NONE;
            endcase
        end
    endfunction

    function [31:0] read_mux;
        input [11:0] addr;
        input [15:0] ctrl;
        input        flag;
        input        lvl;
        begin
            read_mux = 32'h0000_0000;
            if (addr == `CMPEV_ADDR_CONTROL) begin
                read_mux[15:0] = ctrl_mask(ctrl);
                read_mux[`CMPEV_BIT_EVFLAG] = flag;
                read_mux[`CMPEV_BIT_OUT] = lvl;
            end else if (addr == `CMPEV_ADDR_STATUS) begin
                read_mux[0] = lvl;
                read_mux[1] = flag;
            end
        end
    endfunction

    cmpev_edge i_cmpev_edge (
        .i_core_clk    (i_core_clk),
        .i_rst         (i_rst),
        .i_cmp_raw     (i_cmp_raw),
        .i_inversion   (ctrl_reg[`CMPEV_BIT_INV]),
        .i_edge_select (edge_field),
        .o_level       (level),
        .o_hit         (hit)
    );

    assign edge_field = ctrl_reg[`CMPEV_BIT_EDGE_HI:`CMPEV_BIT_EDGE_LO];
    assign ch_field   = ctrl_reg[`CMPEV_BIT_CH_HI:`CMPEV_BIT_CH_LO];

    // Single-cycle access phase: answer in first penable cycle
    assign setup    = i_psel & ~i_penable;
    // Commit only where ready is seen, so a held access cannot write twice
    assign access   = i_psel & i_penable & o_pready;
    assign wr_ctrl  = access & i_pwrite & (i_paddr == `CMPEV_ADDR_CONTROL);
    // Writing one to the flag bit leaves it alone
    assign clr_flag = wr_ctrl & ~i_pwdata[`CMPEV_BIT_EVFLAG];
    assign fire     = hit & ~flag_reg;

    always @* begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = ctrl_mask(i_pwdata[15:0]);
        end
    end

    // Set wins over software clear only while the flag is clear; a hit meeting the clear of a set flag is lost
    always @* begin
        flag_next = flag_reg;
        if (clr_flag) begin
            flag_next = 1'b0;
        end
        if (fire) begin
            flag_next = 1'b1;
        end
    end

    // Pulse stays one cycle wide because firing sets the flag
    always @* begin
        event_next = fire;
    end

    // Ready, error and read data live for exactly one cycle after setup
    always @* begin
        pready_next  = setup;
        pslverr_next = setup & ~addr_mapped(i_paddr);
        prdata_next  = 32'h0000_0000;
        if (setup) begin
            prdata_next = read_mux(i_paddr, ctrl_reg, flag_reg, level);
        end
    end

    always @* begin
        refsel_next = ctrl_reg[`CMPEV_BIT_REFSEL];
        neg_next    = neg_decode(ch_field, ctrl_reg[`CMPEV_BIT_OP_AMP_MODE]);
        inv_next    = ctrl_reg[`CMPEV_BIT_INV];
        opm_next    = ctrl_reg[`CMPEV_BIT_OP_AMP_MODE];
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_reg <= `CMPEV_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_event <= 1'b0;
        end else begin
            o_event <= event_next;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= pready_next;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pslverr <= 1'b0;
        end else begin
            o_pslverr <= pslverr_next;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
        end else begin
            o_prdata <= prdata_next;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_reference_select <= 1'b0;
        end else begin
            o_reference_select <= refsel_next;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_negative_select <= `CMPEV_NEG_NONE;
        end else begin
            o_negative_select <= neg_next;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_output_inversion <= 1'b0;
        end else begin
            o_output_inversion <= inv_next;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_op_amp_mode <= 1'b0;
        end else begin
            o_op_amp_mode <= opm_next;
        end
    end
endmodule

// File: verification/cmpev_sva.sv
// Port-level assertions for the comparator event select block
`timescale 1ns/10ps
`include "cmpev_consts.vh"
module cmpev_sva (
    input wire        i_core_clk,
    input wire        i_rst,
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire        o_pready,
    input wire        o_pslverr,
    input wire        i_cmp_raw,
    input wire        o_event,
    input wire        o_reference_select,
    input wire [1:0]  o_negative_select
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire wr = i_psel && i_penable && i_pwrite && o_pready && i_paddr == `CMPEV_ADDR_CONTROL;
    // Op-amp mode hides the second negative pin
    wire [1:0] nsel = i_pwdata[1:0] == 2'b00 ? `CMPEV_NEG_PIN1 :
        (i_pwdata[1:0] == 2'b01 && !i_pwdata[10]) ? `CMPEV_NEG_PIN2 : `CMPEV_NEG_NONE;
    a_ready_pulse: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
        else $error("ready not a single pulse after setup");
    a_ready_cause: assert property (o_pready |-> $past(i_psel) && !$past(i_penable))
        else $error("ready without setup");
    a_err_unmapped: assert property (o_pslverr |-> o_pready && i_paddr != 12'h000
        && i_paddr != 12'h004) else $error("error on mapped address");
    a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside answer");
    a_ref_follow: assert property (wr |-> ##2 o_reference_select == $past(i_pwdata[4], 2))
        else $error("reference select wrong");
    a_neg_map: assert property (wr |-> ##2 o_negative_select == $past(nsel, 2))
        else $error("negative select wrong");
    a_event_single: assert property (o_event |=> !o_event)
        else $error("event longer than one cycle");
    a_event_cause: assert property (o_event |-> $past(i_cmp_raw, 3) != $past(i_cmp_raw, 4))
        else $error("event without output change");
endmodule
bind cmpev_top cmpev_sva i_cmpev_sva (.*);

// File: verification/cmpev_analog.sv
// Behavioural comparator core driving the raw output
`timescale 1ns/10ps
module cmpev_analog (
    input  wire logic i_core_clk,
    input  wire logic i_level,
    output logic      o_cmp_raw = 1'b0
);
    // Moves just after an edge, unrelated to any bus access
    always @(posedge i_core_clk) o_cmp_raw <= i_level;
endmodule

// File: verification/comparator_event_select_bench.sv
// Self-checking bench for the comparator event select block
`timescale 1ns/10ps
`include "cmpev_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module comparator_event_select_bench;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, lvl = 0, raw, err;
    logic        pready, pslverr, ev, rsel, inv, opm;
    logic [11:0] addr = 0;
    logic [31:0] wd = 0, rd, prdata;
    logic [1:0]  nsel;
    int          fails = 0, num_checks = 0;
    initial forever #25 clk = ~clk;
    cmpev_top i_cmpev_top (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_cmp_raw(raw), .o_event(ev), .o_reference_select(rsel),
        .o_negative_select(nsel), .o_output_inversion(inv), .o_op_amp_mode(opm));
    cmpev_analog i_cmpev_analog (.i_core_clk(clk), .i_level(lvl), .o_cmp_raw(raw));
    task final_report;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1; pen <= 0; pwr <= w; addr <= a; wd <= d;
        @(posedge clk) pen <= 1;
        k = 0;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin fails++; final_report; end
        rd = prdata; err = pslverr; psel <= 0; pen <= 0;
        @(posedge clk);
    endtask
    // Second write clears any event flag left by the settings change
    task set_ctrl(input logic [15:0] v);
        apb(1, `CMPEV_ADDR_CONTROL, {16'h0, v});
        repeat (8) @(posedge clk);
        apb(1, `CMPEV_ADDR_CONTROL, {16'h0, v});
    endtask
    task toggle(output int c);
        lvl <= ~lvl; c = 0;
        repeat (10) @(posedge clk) if (ev === 1'b1) c++;
    endtask
    task t_regs;
        apb(0, `CMPEV_ADDR_CONTROL, 0); `CHK(rd, 32'h0)
        apb(0, 12'h008, 0); `CHK({err, rd}, 33'h100000000)
        set_ctrl(16'hfe3f); apb(0, `CMPEV_ADDR_CONTROL, 0); `CHK(rd, 32'h0413)
        `CHK({rsel, nsel, opm, inv}, 5'b10010)
        set_ctrl(16'h0401); `CHK(nsel, 2'b00)
        set_ctrl(16'h0001); `CHK({rsel, nsel}, 3'b010)
        set_ctrl(16'h0000); `CHK(nsel, 2'b01)
    endtask
    task t_edges;
        int c;
        for (int i = 0; i < 8; i++) begin
            set_ctrl({7'h0, i[2], i[1:0], 6'h0}); toggle(c);
            `CHK(inv, i[2])
            `CHK(c, int'(i % 4 == 3 || i == 1 || i == 6))
            set_ctrl({7'h0, i[2], i[1:0], 6'h0}); toggle(c);
            `CHK(c, int'(i % 4 == 3 || i == 2 || i == 5))
        end
    endtask
    task t_flag;
        int c;
        set_ctrl(16'h00c0); toggle(c); `CHK(c, 1)
        apb(0, `CMPEV_ADDR_CONTROL, 0); `CHK(rd, 32'ha0c0)
        apb(0, `CMPEV_ADDR_STATUS, 0); `CHK(rd[1:0], 2'b11)
        toggle(c); `CHK(c, 0)
        apb(1, `CMPEV_ADDR_CONTROL, 32'h00c0); toggle(c); `CHK(c, 1)
        // Clear lands on the same edge as a new event: the set must win
        apb(1, `CMPEV_ADDR_CONTROL, 32'h00c0); lvl <= ~lvl; repeat (2) @(posedge clk);
        apb(1, `CMPEV_ADDR_CONTROL, 32'h00c0); apb(0, `CMPEV_ADDR_STATUS, 0);
        `CHK(rd[1:0], 2'b10)
    endtask
    task t_reset;
        set_ctrl(16'h0510); rst <= 1; repeat (3) @(posedge clk);
        `CHK({rsel, nsel, opm, inv}, 5'b00000)
        rst <= 0; repeat (2) @(posedge clk); `CHK(nsel, 2'b01)
        apb(0, `CMPEV_ADDR_CONTROL, 0); `CHK(rd, 32'h0)
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_regs;
        t_edges;
        t_flag;
        t_reset;
        final_report;
    end
endmodule
